// ---- hdl/hms_pkg.sv ----
package hms_pkg;
   localparam int NUM_FIBRES = 12; // Link monitors
   localparam int NUM_CHIPS = 24; // Two chips per fibre
   localparam int TICK_PERIOD = 70; // Cycles between tick marks
   localparam int FRAME_PHASE = 2; // Tick phase opening a frame
   localparam int HDR_RUN = 4; // Highs forming a header strobe
   localparam int FRAME_TAIL = 274; // Strobe to next tick phase 0
   localparam int HDR_BITS = 8; // Header width per chip
   localparam int HDR_SAMPLES = 16; // Interleaved header samples
   localparam int STAT_W = 6; // Status word per monitor
   localparam int SHIFT_LEN = HDR_BITS + NUM_FIBRES * STAT_W + 1;
   // Register byte offsets
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_SIDE = 8'h04;
   localparam logic [7:0] OFS_NUM_EN = 8'h08;
   localparam logic [7:0] OFS_LOCK = 8'h0C;
   localparam logic [7:0] OFS_RESULT = 8'h10;
   // Reset values
   localparam logic [23:0] RST_ENABLE = 24'hFFFFFF;
   localparam logic [11:0] RST_SIDE = 12'h000;
   localparam logic [4:0] RST_NUM_EN = 5'h18;
   // Result register field position
   localparam int RES_FAULT = 8;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Supervisor states, Gray along the path
   typedef enum logic [1:0] {
      SV_IDLE = 2'h0,
      SV_HDR = 2'h1,
      SV_SHIFT = 2'h3
   } hms_sv_e;
endpackage

// ---- hdl/hms_sync_monitor.sv ----
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module hms_sync_monitor
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [11:0] fibre_in,
   output logic coincidence_strobe,
   output logic vote_bit,
   output logic [4:0] slice_total,
   output logic fault,
   output logic ser_data,
   output logic ser_valid,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Whole module state in one record
   typedef struct packed {
      logic [11:0] meta; // First synchroniser stage
      logic [11:0] sync; // Second stage, the usable sample
      logic [11:0][6:0] tick; // Tick phase per monitor
      logic [11:0][8:0] fcnt; // Position inside a frame
      logic [11:0] in_frame;
      logic [11:0] locked;
      logic [11:0] run; // Frame opening run still high
      logic [11:0] strobe; // Header strobe pulses
      logic [11:0] tm_n; // Timing status, active low
      logic [23:0] hm_n; // Header status per chip
      logic [23:0] ce_n; // Chip error status per chip
      hms_pkg::hms_sv_e sv;
      logic [4:0] pc; // Sample index in extraction
      logic [23:0] part; // Chips still voting
      logic [23:0] seen; // Chips that joined the event
      logic [11:0] b0; // Held first-chip sample
      logic [7:0] median;
      logic fault;
      logic evt;
      logic vote;
      logic [4:0] total;
      logic [80:0] shreg;
      logic [6:0] shcnt;
      logic ser_d;
      logic ser_v;
      logic [23:0] cfg_en;
      logic [11:0] cfg_side;
      logic [4:0] num_en;
      logic aw_ok;
      logic [7:0] awa;
      logic w_ok;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
   } hms_state_s;

   hms_state_s st_ff; // Registered state
   hms_state_s nxt_st; // Next state

   // Number of ones in a chip-wide vector
   function automatic logic [4:0] ones24(input logic [23:0] v);
      logic [4:0] c;
      c = 5'h00;
      for (int i = 0; i < hms_pkg::NUM_CHIPS; i++)
      begin
         c = c + 5'(v[i]);
      end
      return c;
   endfunction

   // Chips expected to work on one fibre
   function automatic logic [1:0] chip_mask(input logic [1:0] en,
                                            input logic side);
      logic [1:0] r;
      r = 2'h0;
      if (en == 2'h1)
      begin
         r = side ? 2'h2 : 2'h1;
      end
      else if (en != 2'h0)
      begin
         r = 2'h3;
      end
      return r;
   endfunction

   // Per-fibre pair into chip order, first chip in the even slot
   function automatic logic [23:0] weave(input logic [11:0] a,
                                         input logic [11:0] b);
      logic [23:0] r;
      r = 24'h000000;
      for (int i = 0; i < hms_pkg::NUM_FIBRES; i++)
      begin
         r[2 * i] = a[i];
         r[2 * i + 1] = b[i];
      end
      return r;
   endfunction

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[8 * i +: 8] = d[8 * i +: 8];
         end
      end
      return r;
   endfunction

   // Next-state logic
   always_comb
   begin
      logic [23:0] cm;
      logic [11:0] act;
      logic [23:0] bits;
      logic [23:0] diff;
      logic [4:0] ones;
      logic [4:0] nact;
      logic [71:0] stw;
      logic x;
      logic nv;
      logic [31:0] rdv;
      cm = 24'h000000;
      act = 12'h000;
      bits = 24'h000000;
      diff = 24'h000000;
      ones = 5'h00;
      nact = 5'h00;
      stw = 72'h0;
      x = 1'b0;
      nv = 1'b0;
      rdv = 32'h00000000;
      nxt_st = st_ff;

      // Input synchroniser
      nxt_st.meta = fibre_in;
      nxt_st.sync = st_ff.meta;

      // Expected chips and active fibres
      for (int m = 0; m < hms_pkg::NUM_FIBRES; m++)
      begin
         cm[2 * m +: 2] = chip_mask(st_ff.cfg_en[2 * m +: 2],
                                    st_ff.cfg_side[m]);
         act[m] = |cm[2 * m +: 2];
      end
      nact = ones24({12'h000, act});

      // Strict majority only; an even split never fires
      nxt_st.evt = {ones24({12'h000, st_ff.strobe & act}), 1'b0}
                   > {1'b0, nact};

      // Link monitors
      for (int m = 0; m < hms_pkg::NUM_FIBRES; m++)
      begin
         x = st_ff.sync[m];
         nxt_st.strobe[m] = 1'b0;
         if (cm[2 * m +: 2] == 2'h0)
         begin
            // Disabled fibre holds still
            nxt_st.locked[m] = 1'b0;
            nxt_st.in_frame[m] = 1'b0;
            nxt_st.tick[m] = 7'h00;
         end
         else if (st_ff.in_frame[m])
         begin
            // Stuck-high input re-arms here every 280 cycles
            nxt_st.fcnt[m] = st_ff.fcnt[m] + 9'h001;
            if (st_ff.fcnt[m] == 9'(hms_pkg::FRAME_TAIL - 1))
            begin
               nxt_st.in_frame[m] = 1'b0;
               nxt_st.tick[m] = 7'h00;
            end
         end
         else if (!st_ff.locked[m])
         begin
            // Hunting: take a high as the expected tick sample
            if (x)
            begin
               nxt_st.locked[m] = 1'b1;
               nxt_st.tick[m] = cm[2 * m] ? 7'h01 : 7'h02;
            end
         end
         else
         begin
            nxt_st.tick[m] = (st_ff.tick[m] == 7'(hms_pkg::TICK_PERIOD - 1))
                             ? 7'h00 : st_ff.tick[m] + 7'h01;
            // Missing tick half drops lock
            if (!x && ((st_ff.tick[m] == 7'h00 && cm[2 * m]) ||
                       (st_ff.tick[m] == 7'h01 && cm[2 * m + 1])))
            begin
               nxt_st.locked[m] = 1'b0;
            end
            if (st_ff.tick[m] == 7'(hms_pkg::FRAME_PHASE))
            begin
               nxt_st.run[m] = x;
            end
            else if (st_ff.tick[m] <
                     7'(hms_pkg::FRAME_PHASE + hms_pkg::HDR_RUN - 1))
            begin
               nxt_st.run[m] = st_ff.run[m] & x;
            end
            else if (st_ff.tick[m] ==
                     7'(hms_pkg::FRAME_PHASE + hms_pkg::HDR_RUN - 1))
            begin
               // Four highs straight after the tick
               if (st_ff.run[m] && x)
               begin
                  nxt_st.strobe[m] = 1'b1;
                  nxt_st.in_frame[m] = 1'b1;
                  nxt_st.fcnt[m] = 9'h000;
               end
            end
         end
         // Timing status, recovers on a coinciding strobe
         if (st_ff.locked[m] && (st_ff.strobe[m] ^ nxt_st.evt))
         begin
            nxt_st.tm_n[m] = 1'b0;
         end
         else if (st_ff.strobe[m] && nxt_st.evt)
         begin
            nxt_st.tm_n[m] = 1'b1;
         end
      end

      // Supervisor
      bits = weave(st_ff.b0, st_ff.sync);
      nxt_st.ser_v = 1'b0;
      unique case (st_ff.sv)
         hms_pkg::SV_IDLE:
         begin
            // Idle shows the count of locked expected chips
            nxt_st.total = ones24(cm & weave(st_ff.locked,
                                             st_ff.locked));
            if (nxt_st.evt)
            begin
               nxt_st.part = cm & weave(st_ff.strobe, st_ff.strobe);
               nxt_st.seen = nxt_st.part;
               // Joining at the right time clears old header flags
               nxt_st.hm_n = st_ff.hm_n | nxt_st.part;
               nxt_st.b0 = st_ff.sync;
               nxt_st.pc = 5'h01;
               nxt_st.fault = 1'b0;
               nxt_st.median = 8'h00;
               nxt_st.sv = hms_pkg::SV_HDR;
            end
         end
         hms_pkg::SV_HDR:
         begin
            nxt_st.pc = st_ff.pc + 5'h01;
            if (!st_ff.pc[0])
            begin
               nxt_st.b0 = st_ff.sync;
            end
            else if (st_ff.pc < 5'(hms_pkg::HDR_SAMPLES))
            begin
               // Slice count and vote, one bit per sample pair
               ones = ones24(st_ff.part & bits);
               nv = {ones, 1'b0} > {1'b0, ones24(st_ff.part)};
               diff = st_ff.part & (bits ^ {24{nv}});
               nxt_st.vote = nv;
               nxt_st.total = ones;
               nxt_st.median = {st_ff.median[6:0], nv};
               nxt_st.part = st_ff.part & ~diff;
               nxt_st.hm_n = st_ff.hm_n & ~diff;
            end
            else
            begin
               // Error bits of every chip that joined
               ones = ones24(st_ff.seen & bits);
               nxt_st.total = ones;
               nxt_st.ce_n = (st_ff.ce_n & ~st_ff.seen) |
                             (st_ff.seen & bits);
               if (ones != 5'h00 && ones != st_ff.num_en)
               begin
                  nxt_st.fault = 1'b1;
               end
               for (int m = 0; m < hms_pkg::NUM_FIBRES; m++)
               begin
                  stw[hms_pkg::STAT_W * m +: hms_pkg::STAT_W] =
                     {st_ff.locked[m], st_ff.tm_n[m],
                      nxt_st.hm_n[2 * m +: 2],
                      nxt_st.ce_n[2 * m +: 2]};
               end
               nxt_st.shreg = {st_ff.median, stw, nxt_st.fault};
               nxt_st.shcnt = 7'(hms_pkg::SHIFT_LEN);
               nxt_st.sv = hms_pkg::SV_SHIFT;
            end
         end
         hms_pkg::SV_SHIFT:
         begin
            // Median first, then status words, fault last
            nxt_st.ser_v = 1'b1;
            nxt_st.ser_d = st_ff.shreg[80];
            nxt_st.shreg = {st_ff.shreg[79:0], 1'b0};
            nxt_st.shcnt = st_ff.shcnt - 7'h01;
            if (st_ff.shcnt == 7'h01)
            begin
               nxt_st.sv = hms_pkg::SV_IDLE;
            end
         end
         default:
         begin
            // Unused code returns to idle
            nxt_st.sv = hms_pkg::SV_IDLE;
         end
      endcase

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_st.aw_ok = 1'b1;
         nxt_st.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_st.w_ok = 1'b1;
         nxt_st.wd = s_axi_wdata;
         nxt_st.ws = s_axi_wstrb;
      end
      if (st_ff.aw_ok && st_ff.w_ok)
      begin
         nxt_st.aw_ok = 1'b0;
         nxt_st.w_ok = 1'b0;
         nxt_st.bv = 1'b1;
         nxt_st.br = hms_pkg::RESP_OKAY;
         unique case ({st_ff.awa[7:2], 2'h0})
            hms_pkg::OFS_ENABLE:
            begin
               nxt_st.cfg_en = 24'(merge({8'h00, st_ff.cfg_en},
                                         st_ff.wd, st_ff.ws));
            end
            hms_pkg::OFS_SIDE:
            begin
               nxt_st.cfg_side = 12'(merge({20'h00000, st_ff.cfg_side},
                                           st_ff.wd, st_ff.ws));
            end
            hms_pkg::OFS_NUM_EN:
            begin
               nxt_st.num_en = 5'(merge({27'h0, st_ff.num_en},
                                        st_ff.wd, st_ff.ws));
            end
            hms_pkg::OFS_LOCK, hms_pkg::OFS_RESULT:
            begin
               // Read-only, write dropped
               nxt_st.br = hms_pkg::RESP_OKAY;
            end
            default:
            begin
               nxt_st.br = hms_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st_ff.bv && s_axi_bready)
      begin
         nxt_st.bv = 1'b0;
      end

      // Read channel, answered the cycle after the address
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxt_st.rv = 1'b1;
         nxt_st.rr = hms_pkg::RESP_OKAY;
         unique case ({s_axi_araddr[7:2], 2'h0})
            hms_pkg::OFS_ENABLE: rdv = {8'h00, st_ff.cfg_en};
            hms_pkg::OFS_SIDE: rdv = {20'h00000, st_ff.cfg_side};
            hms_pkg::OFS_NUM_EN: rdv = {27'h0, st_ff.num_en};
            hms_pkg::OFS_LOCK: rdv = {20'h00000, st_ff.locked};
            hms_pkg::OFS_RESULT:
            begin
               rdv = {23'h0, st_ff.fault, st_ff.median};
            end
            default:
            begin
               nxt_st.rr = hms_pkg::RESP_SLVERR;
            end
         endcase
         nxt_st.rd = rdv;
      end
      else if (st_ff.rv && s_axi_rready)
      begin
         nxt_st.rv = 1'b0;
      end
   end

   // State register; reset loads constants only
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_ff <= '0;
         st_ff.tm_n <= 12'hFFF;
         st_ff.hm_n <= 24'hFFFFFF;
         st_ff.ce_n <= 24'hFFFFFF;
         st_ff.sv <= hms_pkg::SV_IDLE;
         st_ff.cfg_en <= hms_pkg::RST_ENABLE;
         st_ff.cfg_side <= hms_pkg::RST_SIDE;
         st_ff.num_en <= hms_pkg::RST_NUM_EN;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs; handshake readies are combinational
   assign coincidence_strobe = st_ff.evt;
   assign vote_bit = st_ff.vote;
   assign slice_total = st_ff.total;
   assign fault = st_ff.fault;
   assign ser_data = st_ff.ser_d;
   assign ser_valid = st_ff.ser_v;
   assign s_axi_awready = !st_ff.aw_ok && !st_ff.bv;
   assign s_axi_wready = !st_ff.w_ok && !st_ff.bv;
   assign s_axi_bresp = st_ff.br;
   assign s_axi_bvalid = st_ff.bv;
   assign s_axi_arready = !st_ff.rv;
   assign s_axi_rdata = st_ff.rd;
   assign s_axi_rresp = st_ff.rr;
   assign s_axi_rvalid = st_ff.rv;

endmodule

// ---- tb/hms_sync_checker.sv ----
`timescale 1ns/1ps
// Port-level watch on the sync supervisor
module hms_sync_checker
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic coincidence_strobe,
   input wire logic fault,
   input wire logic [4:0] slice_total,
   input wire logic ser_valid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   logic [6:0] run_ff; // Cycles of the current serial burst
   // Restart the burst count whenever the packet pauses
   always_ff @(posedge ref_clk)
   begin
      if (rst || !ser_valid)
         run_ff <= 7'h00;
      else
         run_ff <= run_ff + 7'h01;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   strobe_one_a: assert property (
      coincidence_strobe |=> !coincidence_strobe)
      else $error("Coincidence strobe wider than one cycle");
   shift_start_a: assert property (
      coincidence_strobe |-> ##18 $rose(ser_valid))
      else $error("Packet did not start on time");
   packet_len_a: assert property (
      $fell(ser_valid) |-> run_ff == 7'h51)
      else $error("Packet length wrong");
   shift_cause_a: assert property (
      $rose(ser_valid) |-> $past(coincidence_strobe, 18))
      else $error("Packet without a preceding event");
   fault_time_a: assert property (
      $rose(fault) |-> $past(coincidence_strobe, 17))
      else $error("Fault set outside its slot");
   fault_hold_a: assert property (
      ser_valid |-> $stable(fault))
      else $error("Fault moved during readout");
   total_max_a: assert property (
      slice_total <= 5'h18)
      else $error("Slice count above chip total");
   read_next_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late");
   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("Write answer dropped early");
endmodule

bind hms_sync_monitor hms_sync_checker u_chk
(
   .ref_clk(ref_clk), .rst(rst), .coincidence_strobe(coincidence_strobe),
   .fault(fault), .slice_total(slice_total), .ser_valid(ser_valid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready)
);

// ---- tb/hms_link_model.sv ----
`timescale 1ns/1ps
// Twelve links: ticks outside frames, a frame on request
module hms_link_model
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [11:0] fmask,
   input wire logic [7:0] hdr [12],
   input wire logic [1:0] eok [12],
   input wire logic [1:0] con [12],
   output logic [11:0] fibre_in,
   output logic busy
);
   logic [6:0] ph_ff; // Tick phase 0..69
   logic [8:0] k_ff; // Frame sample, 0 outside frames
   logic pend_ff; // Frame waits for the next tick
   logic [11:0] fm_ff; // Fibres carrying this frame
   int i;
   int j;
   assign busy = pend_ff || (k_ff != 9'h000);
   // Frame opens after a tick and runs 278 cycles, up to the tick four periods on
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ph_ff <= 7'h00;
         k_ff <= 9'h000;
         pend_ff <= 1'b0;
         fm_ff <= 12'h000;
      end
      else
      begin
         ph_ff <= (ph_ff == 7'h45) ? 7'h00 : ph_ff + 7'h01;
         pend_ff <= pend_ff || go;
         if (k_ff != 9'h000)
            k_ff <= (k_ff == 9'h117) ? 9'h000 : k_ff + 9'h001;
         else if (pend_ff && ph_ff == 7'h01)
         begin
            k_ff <= 9'h002;
            pend_ff <= 1'b0;
            fm_ff <= fmask;
         end
      end
   end
   // Absent chips leave their slots low, so a dead fibre sits at 0
   always_comb
   begin
      for (i = 0; i < 12; i++)
      begin
         j = int'(k_ff) - 6;
         if (k_ff == 9'h000 || !fm_ff[i])
            fibre_in[i] = ph_ff < 7'h02 && con[i][ph_ff[0]];
         else if (j < 0)
            fibre_in[i] = con[i] != 2'b00;
         else if (j < 16)
            fibre_in[i] = hdr[i][7 - j / 2] && con[i][j % 2];
         else if (j < 18)
            fibre_in[i] = eok[i][j - 16] && con[i][j - 16];
         else
            fibre_in[i] = 1'b0;
      end
   end
endmodule

// ---- tb/hms_sync_monitor_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   err_total++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
// Bench: link stand-in, register traffic, packet capture
module hms_sync_monitor_bench;
   logic ref_clk = 1'b0; // 40 ns period
   logic rst = 1'b1; // Held for 20 cycles
   logic [11:0] fibre_in;
   logic coincidence_strobe, vote_bit, fault, ser_data, ser_valid, busy;
   logic [4:0] slice_total;
   logic [7:0] awa = 8'h00, ara = 8'h00; // Bus addresses
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [31:0] wd = 32'h0, rd;
   logic awr, wr, bv, arr, rv;
   logic [1:0] br, rr;
   logic go = 1'b0; // Frame request to the links
   logic [11:0] fm = 12'h000, sd = 12'h000;
   logic [7:0] hdr [12];
   logic [1:0] eok [12], con [12], en [12];
   logic [5:0] st [12]; // Expected status words
   logic [4:0] num_en = 5'h18;
   int err_total = 0, check_count = 0, seed = 32'hE89B;
   always #20 ref_clk = ~ref_clk;
   hms_sync_monitor DUT (.ref_clk(ref_clk), .rst(rst), .fibre_in(fibre_in),
      .coincidence_strobe(coincidence_strobe), .vote_bit(vote_bit),
      .slice_total(slice_total), .fault(fault), .ser_data(ser_data),
      .ser_valid(ser_valid), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
   hms_link_model LNK (.ref_clk(ref_clk), .rst(rst), .go(go), .fmask(fm),
      .hdr(hdr), .eok(eok), .con(con), .fibre_in(fibre_in), .busy(busy));
   // Verdict and end of run
   task automatic final_report;
      begin
         $display("Checks %0d mismatches %0d", check_count, err_total);
         if (err_total == 0 && check_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // A wait ran out
   task automatic tmo;
      begin
         err_total++;
         final_report();
      end
   endtask
   // One bus transfer; readies sampled mid-cycle, acted on at the edge
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
      logic pa, pw, ta, tw, t;
      int n;
      begin
         pa = 1'b1;
         pw = w;
         t = 1'b0;
         n = 0;
         @(posedge ref_clk);
         awa <= a;
         ara <= a;
         wd <= d;
         awv <= w;
         arv <= !w;
         wv <= w;
         while (pa || pw)
         begin
            @(negedge ref_clk);
            ta = pa && (w ? awr : arr);
            tw = pw && wr;
            @(posedge ref_clk);
            pa = pa && !ta;
            pw = pw && !tw;
            awv <= w && pa;
            arv <= !w && pa;
            wv <= pw;
            n++;
            if (n > 200) tmo();
         end
         bry <= w;
         rry <= !w;
         while (!t)
         begin
            @(negedge ref_clk);
            t = w ? bv : rv;
            q = rd;
            r = w ? br : rr;
            @(posedge ref_clk);
            n++;
            if (n > 400) tmo();
         end
         bry <= 1'b0;
         rry <= 1'b0;
      end
   endtask
   // Median by bitwise vote, losers drop out
   function automatic logic [7:0] exp_med(input logic [11:0] m);
      logic [23:0] al;
      logic [7:0] md;
      int b, c, ones, nc;
      begin
         for (c = 0; c < 24; c++)
            al[c] = m[c / 2] && con[c / 2][c % 2];
         for (b = 7; b >= 0; b--)
         begin
            ones = 0;
            nc = 0;
            for (c = 0; c < 24; c++)
               if (al[c])
               begin
                  nc++;
                  ones += int'(hdr[c / 2][b]);
               end
            md[b] = 2 * ones > nc;
            for (c = 0; c < 24; c++)
               al[c] = al[c] && (hdr[c / 2][b] == md[b]);
         end
         return md;
      end
   endfunction
   // One frame on fibres m; bad fibres get a skewed header
   task automatic frame_test(input string nm, input logic [11:0] m,
      input logic [11:0] bad, input logic [11:0] ef, input logic evt);
      logic seen, xf;
      logic [7:0] h, med, v;
      logic [80:0] pk, rx;
      logic [31:0] q;
      logic [1:0] r;
      logic [4:0] ec, ic;
      int f, c, n;
      begin
         h = 8'($random(seed));
         for (f = 0; f < 12; f++)
         begin
            hdr[f] = bad[f] ? h ^ (8'h80 >> (f % 8)) : h;
            eok[f] = ef[f] ? 2'b10 : 2'b11;
         end
         @(posedge ref_clk);
         fm <= m;
         go <= 1'b1;
         @(posedge ref_clk);
         go <= 1'b0;
         seen = 1'b0;
         for (n = 0; n < 160 && !seen; n++)
         begin
            @(posedge ref_clk);
            #1;
            seen = coincidence_strobe;
         end
         `CHK("event", evt, seen)
         if (seen)
         begin
            for (c = 7; c >= 0; c--)
            begin
               repeat ((c == 7) ? 1 : 2) @(posedge ref_clk);
               #1;
               v[c] = vote_bit;
            end
            med = exp_med(m);
            `CHK("vote", med, v)
            repeat (2) @(posedge ref_clk);
            #1;
            ec = 5'h00;
            for (c = 0; c < 24; c++)
               ec += 5'(m[c / 2] && con[c / 2][c % 2] && eok[c / 2][c % 2]);
            xf = (ec != 5'h00) && (ec != num_en);
            `CHK("errors", ec, slice_total)
            `CHK("fault", xf, fault)
            for (f = 0; f < 12; f++)
            begin
               st[f][5:4] = {|en[f], m[f] || (st[f][4] && !en[f])};
               for (c = 0; c < 2; c++)
                  if (m[f] && con[f][c])
                  begin
                     st[f][2 + c] = hdr[f] == med;
                     st[f][c] = eok[f][c];
                  end
            end
            pk = {73'h0, med};
            for (f = 11; f >= 0; f--)
               pk = {pk[74:0], st[f]};
            pk = {pk[79:0], xf};
            for (n = 0; n < 81; n++)
            begin
               @(posedge ref_clk);
               #1;
               rx = {rx[79:0], ser_data};
            end
            `CHK("packet", pk, rx)
            xfer(1'b0, hms_pkg::OFS_RESULT, 32'h0, q, r);
            `CHK("result", {23'h0, xf, med}, q)
         end
         else
            for (f = 0; f < 12; f++)
               st[f][4] = st[f][4] && !m[f];
         for (n = 0; n < 400 && busy; n++)
            @(posedge ref_clk);
         if (busy) tmo();
         repeat (20) @(posedge ref_clk);
         #1;
         ic = 5'h00;
         for (c = 0; c < 24; c++)
            ic += 5'(con[c / 2][c % 2]);
         `CHK("idle count", ic, slice_total)
         $display("Test %s done", nm);
      end
   endtask
   // Main sequence
   initial
   begin
      logic [31:0] q, d;
      logic [1:0] r;
      int f;
      for (f = 0; f < 12; f++)
      begin
         hdr[f] = 8'h00;
         eok[f] = 2'b11;
         con[f] = 2'b11;
         en[f] = 2'b11;
         st[f] = 6'h3F;
      end
      repeat (19) @(posedge ref_clk);
      #1;
      `CHK("reset", 6'h06, {coincidence_strobe, ser_valid, fault, awr, arr, bv})
      @(posedge ref_clk);
      rst <= 1'b0;
      xfer(1'b0, hms_pkg::OFS_ENABLE, 32'h0, q, r);
      `CHK("enable", {8'h00, hms_pkg::RST_ENABLE}, q)
      xfer(1'b0, hms_pkg::OFS_SIDE, 32'h0, q, r);
      `CHK("side", {20'h0, hms_pkg::RST_SIDE}, q)
      xfer(1'b0, hms_pkg::OFS_NUM_EN, 32'h0, q, r);
      `CHK("num_en", {27'h0, hms_pkg::RST_NUM_EN}, q)
      xfer(1'b1, 8'h20, 32'h0, q, r);
      `CHK("unmapped write", hms_pkg::RESP_SLVERR, r)
      xfer(1'b0, 8'h20, 32'h0, q, r);
      `CHK("unmapped read", {hms_pkg::RESP_SLVERR, 32'h0}, {r, q})
      repeat (400) @(posedge ref_clk);
      xfer(1'b0, hms_pkg::OFS_LOCK, 32'h0, q, r);
      `CHK("lock", 32'h0FFF, q)
      frame_test("all", 12'hFFF, 12'h000, 12'h000, 1'b1);
      frame_test("six", 12'h03F, 12'h000, 12'h000, 1'b0);
      frame_test("seven", 12'h07F, 12'h000, 12'h000, 1'b1);
      frame_test("bad", 12'hFFF, 12'h007, 12'h010, 1'b1);
      frame_test("clean", 12'hFFF, 12'h000, 12'h000, 1'b1);
      for (f = 0; f < 3; f++)
      begin
         q = $random(seed);
         d = $random(seed);
         frame_test("random", 12'hFFF, q[11:0], d[11:0], 1'b1);
      end
      en[0] = 2'b00;
      con[0] = 2'b00;
      en[1] = 2'b01;
      con[1] = 2'b10;
      sd[1] = 1'b1;
      num_en = 5'h15;
      d = 32'h0;
      for (f = 0; f < 12; f++)
         d[2 * f +: 2] = en[f];
      xfer(1'b1, hms_pkg::OFS_ENABLE, d, q, r);
      xfer(1'b1, hms_pkg::OFS_SIDE, {20'h0, sd}, q, r);
      xfer(1'b1, hms_pkg::OFS_NUM_EN, {27'h0, num_en}, q, r);
      `CHK("config resp", hms_pkg::RESP_OKAY, r)
      repeat (400) @(posedge ref_clk);
      xfer(1'b0, hms_pkg::OFS_LOCK, 32'h0, q, r);
      `CHK("lock one chip", 32'h0FFE, q)
      frame_test("enable", 12'hFFE, 12'h000, 12'h000, 1'b1);
      final_report();
   end
endmodule
